// ===== gtr_pkg.sv
// Constants for the timer load, match and prescale register block.
// Assumes a 32-bit APB with byte addresses and one system clock.
package gtr_pkg;

  // Bus and field widths
  localparam int DATA_W = 32;
  localparam int ADDR_W = 12;
  localparam int HALF_W = 16;
  localparam int PSC_W = 8;
  localparam int NUM_HALVES = 2;
  localparam int HALF_A = 0;
  localparam int HALF_B = 1;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_A_LOAD = 12'h028;
  localparam logic [ADDR_W-1:0] OFF_B_LOAD = 12'h02C;
  localparam logic [ADDR_W-1:0] OFF_A_MATCH = 12'h030;
  localparam logic [ADDR_W-1:0] OFF_B_MATCH = 12'h034;
  localparam logic [ADDR_W-1:0] OFF_A_PSC = 12'h038;
  localparam logic [ADDR_W-1:0] OFF_B_PSC = 12'h03C;
  localparam logic [ADDR_W-1:0] OFF_A_VALUE = 12'h048;
  localparam logic [ADDR_W-1:0] OFF_B_VALUE = 12'h04C;

  // Reset values
  localparam logic [HALF_W-1:0] RST_LOAD = 16'hFFFF;
  localparam logic [HALF_W-1:0] RST_MATCH = 16'hFFFF;
  localparam logic [PSC_W-1:0] RST_PSC = 8'h00;
  localparam logic [HALF_W-1:0] ZERO_HALF = 16'h0000;
  localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;

endpackage

// ===== gtr_load_match_regs.sv
// Interval load, match and prescale registers of a two-half timer, with
// the match-derived events (RTC match, PWM level, edge-count done).
// Assumes mode and width selects and counter values come from the timer
// core on sys_clk_i; APB master keeps psel/penable protocol.
//
// Notes on behaviour
// - 32-bit: A load upper mirrors B load
// - 16-bit: A load upper reads zero, inert
// - Upper resets FFFF/0000 by width, lower FFFF
// - Writing A load low loads counter A
// - 32-bit: A load upper writes B load
// - 32-bit: B load ignores writes, reads value
// - 16-bit: B load writable, upper reads zero
// - 32-bit RTC: match on both halves equal
// - PWM duty from match and load
// - Edge count ends after load minus match
// - 16-bit: A match upper zero, inert
// - Reserved bits: software preserves, read zero
// - Each half has 8-bit prescale, resets zero
// - Prescale write stores, read returns it
// - Match used only RTC32, PWM16, edge16
// - A value reads counter or edge stamp
//
// The APB register port was decided locally.
`timescale 1ns/100ps
module gtr_load_match_regs
  import gtr_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [DATA_W-1:0] pwdata_i,
  output logic [DATA_W-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Mode selects from the configuration logic
  input wire logic cfg_32bit_i,
  input wire logic rtc_mode_i,
  input wire logic pwm_mode_i,
  input wire logic edge_cnt_mode_i,
  // Counter state from the counting engine
  input wire logic [DATA_W-1:0] a_count_i,
  input wire logic [HALF_W-1:0] b_count_i,
  input wire logic [DATA_W-1:0] a_edge_stamp_i,
  input wire logic [HALF_W-1:0] b_edge_stamp_i,
  // Values to the counting engine
  output logic [HALF_W-1:0] a_load_val_o,
  output logic [HALF_W-1:0] b_load_val_o,
  output logic a_load_pulse_o,
  output logic b_load_pulse_o,
  output logic [HALF_W-1:0] a_match_val_o,
  output logic [HALF_W-1:0] a_match_hi_o,
  output logic [HALF_W-1:0] b_match_val_o,
  output logic [PSC_W-1:0] a_prescale_o,
  output logic [PSC_W-1:0] b_prescale_o,
  // Match events
  output logic rtc_match_o,
  output logic a_pwm_o,
  output logic b_pwm_o,
  output logic a_edge_done_o,
  output logic b_edge_done_o
);

  logic [HALF_W-1:0] a_load_r;
  logic [HALF_W-1:0] b_load_r;
  logic [HALF_W-1:0] a_match_r;
  logic [HALF_W-1:0] a_match_hi_r;
  logic [HALF_W-1:0] b_match_r;
  logic [PSC_W-1:0] a_psc_r;
  logic [PSC_W-1:0] b_psc_r;
  logic a_load_pulse_r;
  logic b_load_pulse_r;
  logic rtc_match_r;
  logic [DATA_W-1:0] prdata_r;
  logic [DATA_W-1:0] rd_nxt;
  logic hit_nxt;
  logic setup;
  logic wr_en;
  logic wr_a_load;
  logic wr_b_load;
  logic wr_a_match;
  logic wr_b_match;
  logic wr_a_psc;
  logic wr_b_psc;
  logic mapped;
  logic rtc_en;
  logic pwm_en;
  logic edge_en;
  logic [HALF_W-1:0] w_lo;
  logic [HALF_W-1:0] w_hi;
  logic [HALF_W-1:0] h_load [NUM_HALVES];
  logic [HALF_W-1:0] h_match [NUM_HALVES];
  logic [HALF_W-1:0] h_count [NUM_HALVES];
  logic [NUM_HALVES-1:0] pwm_r;
  logic [NUM_HALVES-1:0] edge_done_r;

  // Bus decode; zero wait states, so every transfer completes in two cycles, setup plus one access cycle
  assign setup = psel_i && !penable_i;
  assign wr_en = psel_i && penable_i && pwrite_i;
  assign w_lo = pwdata_i[HALF_W-1:0];
  assign w_hi = pwdata_i[DATA_W-1:HALF_W];
  assign wr_a_load = wr_en && (paddr_i == OFF_A_LOAD);
  assign wr_b_load = wr_en && (paddr_i == OFF_B_LOAD);
  assign wr_a_match = wr_en && (paddr_i == OFF_A_MATCH);
  assign wr_b_match = wr_en && (paddr_i == OFF_B_MATCH);
  assign wr_a_psc = wr_en && (paddr_i == OFF_A_PSC);
  assign wr_b_psc = wr_en && (paddr_i == OFF_B_PSC);
  assign mapped = (paddr_i == OFF_A_LOAD) || (paddr_i == OFF_B_LOAD) ||
                  (paddr_i == OFF_A_MATCH) || (paddr_i == OFF_B_MATCH) ||
                  (paddr_i == OFF_A_PSC) || (paddr_i == OFF_B_PSC) ||
                  (paddr_i == OFF_A_VALUE) || (paddr_i == OFF_B_VALUE);
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && !mapped;

  // Match takes part only in these modes; elsewhere the events stay low
  assign rtc_en = cfg_32bit_i && rtc_mode_i;
  assign pwm_en = !cfg_32bit_i && pwm_mode_i;
  assign edge_en = !cfg_32bit_i && edge_cnt_mode_i;

  // Interval load registers
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      a_load_r <= RST_LOAD;
    end else if (wr_a_load) begin
      a_load_r <= w_lo;
    end
  end

  // B load holds the upper half of the 32-bit load; its own port is dead then
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      b_load_r <= RST_LOAD;
    end else if (wr_a_load && cfg_32bit_i) begin
      b_load_r <= w_hi;
    end else if (wr_b_load && !cfg_32bit_i) begin
      b_load_r <= w_lo;
    end
  end

  // Load strobes to the counters, raised on the write edge together with the load value, high for one cycle
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      a_load_pulse_r <= 1'b0;
      b_load_pulse_r <= 1'b0;
    end else begin
      a_load_pulse_r <= wr_a_load;
      b_load_pulse_r <= (wr_a_load && cfg_32bit_i) || (wr_b_load && !cfg_32bit_i);
    end
  end

  // Match registers; A upper only accepts writes in 32-bit width
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      a_match_r <= RST_MATCH;
      a_match_hi_r <= RST_MATCH;
    end else if (wr_a_match) begin
      a_match_r <= w_lo;
      if (cfg_32bit_i) begin
        a_match_hi_r <= w_hi;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      b_match_r <= RST_MATCH;
    end else if (wr_b_match) begin
      b_match_r <= w_lo;
    end
  end

  // Prescalers; upper write bits are reserved and dropped
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      a_psc_r <= RST_PSC;
      b_psc_r <= RST_PSC;
    end else begin
      if (wr_a_psc) begin
        a_psc_r <= pwdata_i[PSC_W-1:0];
      end
      if (wr_b_psc) begin
        b_psc_r <= pwdata_i[PSC_W-1:0];
      end
    end
  end

  // Read mux, captured in the setup cycle so prdata comes from a flop
  always_comb begin
    rd_nxt = ZERO_WORD;
    hit_nxt = 1'b1;
    case (paddr_i)
      OFF_A_LOAD: rd_nxt = {(cfg_32bit_i ? b_load_r : ZERO_HALF), a_load_r};
      OFF_B_LOAD: rd_nxt = {ZERO_HALF, b_load_r};
      OFF_A_MATCH: rd_nxt = {(cfg_32bit_i ? a_match_hi_r : ZERO_HALF), a_match_r};
      OFF_B_MATCH: rd_nxt = {ZERO_HALF, b_match_r};
      OFF_A_PSC: rd_nxt[PSC_W-1:0] = a_psc_r;
      OFF_B_PSC: rd_nxt[PSC_W-1:0] = b_psc_r;
      OFF_A_VALUE: begin
        rd_nxt = edge_cnt_mode_i ? a_edge_stamp_i : a_count_i;
        if (!cfg_32bit_i) begin
          rd_nxt[DATA_W-1:HALF_W] = ZERO_HALF;
        end
      end
      OFF_B_VALUE: rd_nxt = {ZERO_HALF, (edge_cnt_mode_i ? b_edge_stamp_i : b_count_i)};
      default: hit_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      prdata_r <= ZERO_WORD;
    end else if (setup && !pwrite_i) begin
      prdata_r <= hit_nxt ? rd_nxt : ZERO_WORD;
    end
  end

  // RTC match compares the whole 32-bit count against both match halves
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      rtc_match_r <= 1'b0;
    end else begin
      rtc_match_r <= rtc_en && (a_count_i[DATA_W-1:HALF_W] == a_match_hi_r) &&
                     (a_count_i[HALF_W-1:0] == a_match_r);
    end
  end

  assign h_load[HALF_A] = a_load_r;
  assign h_load[HALF_B] = b_load_r;
  assign h_match[HALF_A] = a_match_r;
  assign h_match[HALF_B] = b_match_r;
  assign h_count[HALF_A] = a_count_i[HALF_W-1:0];
  assign h_count[HALF_B] = b_count_i;

  // Per-half events; counters run down from load, so the PWM output is high
  // above match (duty = load - match out of load + 1) and edge counting
  // finishes after load - match edges, when the count reaches match.
  for (genvar h = 0; h < NUM_HALVES; h++) begin : g_half
    always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
        pwm_r[h] <= 1'b0;
        edge_done_r[h] <= 1'b0;
      end else begin
        pwm_r[h] <= pwm_en && (h_count[h] > h_match[h]) &&
                    (h_count[h] <= h_load[h]);
        edge_done_r[h] <= edge_en && (h_count[h] == h_match[h]);
      end
    end
  end

  assign prdata_o = prdata_r;
  assign a_load_val_o = a_load_r;
  assign b_load_val_o = b_load_r;
  assign a_load_pulse_o = a_load_pulse_r;
  assign b_load_pulse_o = b_load_pulse_r;
  assign a_match_val_o = a_match_r;
  assign a_match_hi_o = cfg_32bit_i ? a_match_hi_r : ZERO_HALF;
  assign b_match_val_o = b_match_r;
  assign a_prescale_o = a_psc_r;
  assign b_prescale_o = b_psc_r;
  assign rtc_match_o = rtc_match_r;
  assign a_pwm_o = pwm_r[HALF_A];
  assign b_pwm_o = pwm_r[HALF_B];
  assign a_edge_done_o = edge_done_r[HALF_A];
  assign b_edge_done_o = edge_done_r[HALF_B];

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  a_upper_read_zero: assert property (
    (setup && !pwrite_i && paddr_i == OFF_A_LOAD && !cfg_32bit_i)
      |=> prdata_o[DATA_W-1:HALF_W] == ZERO_HALF)
    else $error("A load upper half not zero in 16-bit read");
  a_upper_write_b: assert property (
    (wr_a_load && cfg_32bit_i) |=> b_load_val_o == $past(pwdata_i[DATA_W-1:HALF_W]))
    else $error("A load upper write did not reach B load");
  a_both_halves: assert property (
    (wr_a_load && cfg_32bit_i) |=> a_load_pulse_o && b_load_pulse_o &&
      a_load_val_o == $past(pwdata_i[HALF_W-1:0]))
    else $error("32-bit load write did not update both halves");
  a_b_ignored_32: assert property (
    (wr_b_load && cfg_32bit_i) |=> $stable(b_load_val_o))
    else $error("B load changed on write in 32-bit width");
  a_b_kept_16: assert property (
    (wr_a_load && !cfg_32bit_i) |=> $stable(b_load_val_o) && !b_load_pulse_o)
    else $error("A load write disturbed B load in 16-bit width");
  a_b_write_16: assert property (
    (wr_b_load && !cfg_32bit_i) |=> b_load_val_o == $past(pwdata_i[HALF_W-1:0]) ##1 !b_load_pulse_o)
    else $error("B load write lost in 16-bit width");
  a_rtc_match_evt: assert property (
    rtc_match_o == $past(rtc_en && !srst_i && a_count_i == {a_match_hi_r, a_match_r}))
    else $error("RTC match event wrong");
  a_psc_store: assert property (
    wr_a_psc |=> a_prescale_o == $past(pwdata_i[PSC_W-1:0]))
    else $error("Prescale write not stored");
  a_match_gated: assert property (
    (!cfg_32bit_i && !pwm_mode_i && !edge_cnt_mode_i)[*2] |-> ##0
      !a_pwm_o && !b_pwm_o && !a_edge_done_o && !b_edge_done_o && !rtc_match_o)
    else $error("Match event outside its modes");
  a_edge_done_evt: assert property (
    (edge_en && h_count[HALF_B] == b_match_r) |=> b_edge_done_o)
    else $error("Edge count completion missed");
  a_value_read: assert property (
    (setup && !pwrite_i && paddr_i == OFF_A_VALUE && cfg_32bit_i && edge_cnt_mode_i)
      |=> prdata_o == $past(a_edge_stamp_i))
    else $error("A value read did not return edge stamp");

  c_load_32: cover property (wr_a_load && cfg_32bit_i);
  c_rtc_hit: cover property (rtc_match_o);
  c_pwm_toggle: cover property (a_pwm_o ##1 !a_pwm_o);
  c_edge_done: cover property (a_edge_done_o);

endmodule

// ===== gtr_load_match_regs_tb.sv
// Self-checking bench for the timer load, match and prescale registers.
// Assumes the block sits alone on APB; the bench drives all mode and count inputs.
`timescale 1ns/100ps
module gtr_load_match_regs_tb;
  import gtr_pkg::*;
  typedef struct {
    logic cfg;
    logic [ADDR_W-1:0] waddr;
    logic [DATA_W-1:0] wdata;
    logic [ADDR_W-1:0] raddr;
    logic [DATA_W-1:0] exp;
  } gtr_row_s;
  logic sys_clk_i, srst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic cfg_32bit_i, rtc_mode_i, pwm_mode_i, edge_cnt_mode_i;
  logic [ADDR_W-1:0] paddr_i;
  logic [DATA_W-1:0] pwdata_i, prdata_o, a_count_i, a_edge_stamp_i, rd;
  logic [HALF_W-1:0] b_count_i, b_edge_stamp_i, a_load_val_o, b_load_val_o;
  logic [HALF_W-1:0] a_match_val_o, a_match_hi_o, b_match_val_o;
  logic [PSC_W-1:0] a_prescale_o, b_prescale_o;
  logic a_load_pulse_o, b_load_pulse_o, rtc_match_o, a_pwm_o, b_pwm_o;
  logic a_edge_done_o, b_edge_done_o, err;
  int error_cnt = 0;
  int tests_run = 0;
  gtr_row_s rows [12];

  gtr_load_match_regs i_dut (
    .sys_clk_i(sys_clk_i), .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .cfg_32bit_i(cfg_32bit_i),
    .rtc_mode_i(rtc_mode_i), .pwm_mode_i(pwm_mode_i), .edge_cnt_mode_i(edge_cnt_mode_i),
    .a_count_i(a_count_i), .b_count_i(b_count_i), .a_edge_stamp_i(a_edge_stamp_i),
    .b_edge_stamp_i(b_edge_stamp_i), .a_load_val_o(a_load_val_o), .b_load_val_o(b_load_val_o),
    .a_load_pulse_o(a_load_pulse_o), .b_load_pulse_o(b_load_pulse_o),
    .a_match_val_o(a_match_val_o), .a_match_hi_o(a_match_hi_o), .b_match_val_o(b_match_val_o),
    .a_prescale_o(a_prescale_o), .b_prescale_o(b_prescale_o), .rtc_match_o(rtc_match_o),
    .a_pwm_o(a_pwm_o), .b_pwm_o(b_pwm_o), .a_edge_done_o(a_edge_done_o),
    .b_edge_done_o(b_edge_done_o)
  );

  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end

  task automatic test_done();
    $display("counts: %0d checks, %0d mismatches", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk_word(input string name, input logic [DATA_W-1:0] exp,
                          input logic [DATA_W-1:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_bit(input string name, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %b seen %b", name, exp, got);
    end
  endtask

  // One APB transfer; an idle cycle before it keeps each signal to one assignment per step
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] addr,
                     input logic [DATA_W-1:0] wdata);
    @(posedge sys_clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= addr;
    pwdata_i <= wdata;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    // A slave that never answers is caught by the watchdog
    do begin
      @(posedge sys_clk_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  initial begin
    repeat (5000) @(posedge sys_clk_i);
    error_cnt++;
    test_done();
  end

  initial begin
    rows = '{
      '{1'b1, OFF_A_LOAD, 32'h1234_5678, OFF_A_LOAD, 32'h1234_5678},
      '{1'b1, OFF_A_LOAD, 32'h9ABC_DEF0, OFF_B_LOAD, 32'h0000_9ABC},
      '{1'b1, OFF_B_LOAD, 32'h0000_5555, OFF_B_LOAD, 32'h0000_9ABC},
      '{1'b0, OFF_B_LOAD, 32'h0000_4321, OFF_B_LOAD, 32'h0000_4321},
      '{1'b0, OFF_A_LOAD, 32'hAAAA_1111, OFF_A_LOAD, 32'h0000_1111},
      '{1'b0, OFF_A_LOAD, 32'hBBBB_2222, OFF_B_LOAD, 32'h0000_4321},
      '{1'b1, OFF_A_MATCH, 32'h1357_2468, OFF_A_MATCH, 32'h1357_2468},
      '{1'b0, OFF_A_MATCH, 32'h7777_0042, OFF_A_MATCH, 32'h0000_0042},
      '{1'b0, OFF_B_MATCH, 32'h0000_0099, OFF_B_MATCH, 32'h0000_0099},
      '{1'b0, OFF_A_PSC, 32'h0000_00A5, OFF_A_PSC, 32'h0000_00A5},
      '{1'b0, OFF_B_PSC, 32'h0000_005A, OFF_B_PSC, 32'h0000_005A},
      '{1'b1, OFF_A_PSC, 32'h0000_00A5, OFF_A_MATCH, 32'h1357_0042}};
    srst_i = 1'b1;
    {psel_i, penable_i, pwrite_i, cfg_32bit_i} = 4'h0;
    {rtc_mode_i, pwm_mode_i, edge_cnt_mode_i} = 3'h0;
    paddr_i = 12'h000;
    pwdata_i = 32'h0000_0000;
    a_count_i = 32'h0000_0000;
    a_edge_stamp_i = 32'h0000_0000;
    b_count_i = 16'h0000;
    b_edge_stamp_i = 16'h0000;
    repeat (4) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    foreach (rows[i]) begin
      cfg_32bit_i <= rows[i].cfg;
      apb(1'b1, rows[i].waddr, rows[i].wdata);
      apb(1'b0, rows[i].raddr, 32'h0000_0000);
      chk_word("readback", rows[i].exp, rd);
    end // Row tags also
    $display("test register table done");
    srst_i <= 1'b1;
    @(posedge sys_clk_i);
    srst_i <= 1'b0;
    cfg_32bit_i <= 1'b1;
    apb(1'b0, OFF_A_LOAD, 32'h0000_0000);
    chk_word("a load reset wide", 32'hFFFF_FFFF, rd);
    apb(1'b0, OFF_A_MATCH, 32'h0000_0000);
    chk_word("a match reset wide", 32'hFFFF_FFFF, rd);
    cfg_32bit_i <= 1'b0;
    apb(1'b0, OFF_A_LOAD, 32'h0000_0000);
    chk_word("a load reset narrow", 32'h0000_FFFF, rd);
    apb(1'b0, OFF_B_PSC, 32'h0000_0000);
    chk_word("b prescale reset", 32'h0000_0000, rd);
    apb(1'b0, 12'h040, 32'h0000_0000);
    chk_bit("unmapped error", 1'b1, err);
    chk_word("unmapped data", 32'h0000_0000, rd);
    $display("test reset and unmapped done");
    cfg_32bit_i <= 1'b1;
    apb(1'b1, OFF_A_LOAD, 32'hBEEF_0123);
    #1;
    chk_bit("a load pulse", 1'b1, a_load_pulse_o);
    chk_bit("b load pulse", 1'b1, b_load_pulse_o);
    chk_word("load pair", 32'hBEEF_0123, {b_load_val_o, a_load_val_o});
    @(posedge sys_clk_i);
    #1;
    chk_bit("a load pulse end", 1'b0, a_load_pulse_o);
    @(posedge sys_clk_i);
    cfg_32bit_i <= 1'b0;
    apb(1'b1, OFF_A_LOAD, 32'h0000_0077);
    #1;
    chk_bit("a load pulse narrow", 1'b1, a_load_pulse_o);
    chk_bit("b load pulse narrow", 1'b0, b_load_pulse_o);
    $display("test load pulses done");
    apb(1'b1, OFF_A_MATCH, 32'h0000_0010);
    apb(1'b1, OFF_B_MATCH, 32'h0000_0020);
    edge_cnt_mode_i <= 1'b1;
    a_count_i <= 32'h0000_0010;
    b_count_i <= 16'h0020;
    a_edge_stamp_i <= 32'h1234_ABCD;
    apb(1'b0, OFF_A_VALUE, 32'h0000_0000);
    chk_word("a value stamp", 32'h0000_ABCD, rd);
    chk_bit("a edge done", 1'b1, a_edge_done_o);
    chk_bit("b edge done", 1'b1, b_edge_done_o);
    chk_bit("rtc off narrow", 1'b0, rtc_match_o);
    b_edge_stamp_i <= 16'h5A5A;
    apb(1'b0, OFF_B_VALUE, 32'h0000_0000);
    chk_word("b value stamp", 32'h0000_5A5A, rd);
    cfg_32bit_i <= 1'b1;
    apb(1'b0, OFF_A_VALUE, 32'h0000_0000);
    chk_word("a value stamp wide", 32'h1234_ABCD, rd);
    cfg_32bit_i <= 1'b0;
    edge_cnt_mode_i <= 1'b0;
    pwm_mode_i <= 1'b1;
    a_count_i <= 32'h0000_0050;
    b_count_i <= 16'h0010;
    apb(1'b0, OFF_A_VALUE, 32'h0000_0000);
    chk_word("a value live", 32'h0000_0050, rd);
    chk_bit("a pwm", 1'b1, a_pwm_o);
    chk_bit("b pwm", 1'b0, b_pwm_o);
    chk_bit("edge off in pwm", 1'b0, a_edge_done_o);
    $display("test edge and pwm done");
    pwm_mode_i <= 1'b0;
    rtc_mode_i <= 1'b1;
    cfg_32bit_i <= 1'b1;
    apb(1'b1, OFF_A_MATCH, 32'h0001_0002);
    a_count_i <= 32'h0001_0002;
    apb(1'b0, OFF_A_MATCH, 32'h0000_0000);
    chk_word("a match wide", 32'h0001_0002, rd);
    chk_bit("rtc match", 1'b1, rtc_match_o);
    a_count_i <= 32'h0002_0002;
    apb(1'b0, OFF_A_VALUE, 32'h0000_0000);
    chk_word("a value wide", 32'h0002_0002, rd);
    chk_bit("rtc upper differs", 1'b0, rtc_match_o);
    chk_word("a match outputs", 32'h0001_0002, {a_match_hi_o, a_match_val_o});
    chk_word("b match output", 32'h0000_0020, {ZERO_HALF, b_match_val_o});
    $display("test rtc done");
    cfg_32bit_i <= 1'b0;
    apb(1'b1, OFF_A_PSC, 32'h0000_003C);
    apb(1'b1, OFF_B_PSC, 32'h0000_00C3);
    #1;
    chk_word("a match hi narrow", 32'h0000_0002, {a_match_hi_o, a_match_val_o});
    chk_word("prescale outputs", 32'h0000_3CC3, {16'h0000, a_prescale_o, b_prescale_o});
    $display("test register outputs done");
    test_done();
  end
endmodule
